// >>> rtl/lbc_pkg.sv
/*
 * lbc_pkg: register map, field positions, reset values and carrier types
 * for the LED bank configuration register block.
 * Assumes: one 40 MHz core clock; registers are 8 bits wide and are
 * reached over the two-wire serial port of the block.
 */
package lbc_pkg;

  // sizes
  localparam int NREG  = 22;
  localparam int NBANK = 6;
  localparam int NSINK = 7;
  localparam int NZONE = 5;
  localparam int NPAT  = 4;

  // register offsets
  localparam logic [7:0] ADDR_OUT1   = 8'h10;
  localparam logic [7:0] ADDR_OUT2   = 8'h11;
  localparam logic [7:0] ADDR_AB     = 8'h1A;
  localparam logic [7:0] ADDR_LV_C   = 8'h1B;
  localparam logic [7:0] ADDR_FS_A   = 8'h1F;
  localparam logic [7:0] ADDR_ANODE  = 8'h25;
  localparam logic [7:0] ADDR_PUMP   = 8'h26;
  localparam logic [7:0] ADDR_EN     = 8'h27;
  localparam logic [7:0] ADDR_PAT    = 8'h28;
  localparam logic [7:0] ADDR_ZS_HI  = 8'h29;
  localparam logic [7:0] ADDR_ZS_MID = 8'h2A;
  localparam logic [7:0] ADDR_ZS_LO  = 8'h2B;
  localparam logic [7:0] ADDR_BOOST  = 8'h2C;
  localparam logic [7:0] ADDR_ALS    = 8'h30;

  // storage slots
  localparam int IDX_OUT1   = 0;
  localparam int IDX_OUT2   = 1;
  localparam int IDX_AB     = 2;
  localparam int IDX_LV_C   = 3;
  localparam int IDX_FS_A   = 7;
  localparam int IDX_ANODE  = 13;
  localparam int IDX_PUMP   = 14;
  localparam int IDX_EN     = 15;
  localparam int IDX_PAT    = 16;
  localparam int IDX_ZS_HI  = 17;
  localparam int IDX_ZS_MID = 18;
  localparam int IDX_ZS_LO  = 19;
  localparam int IDX_BOOST  = 20;
  localparam int IDX_ALS    = 21;

  // reset values
  localparam logic [7:0] OUT1_RST  = 8'h92;
  localparam logic [7:0] OUT2_RST  = 8'h0F;
  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam logic [7:0] FS_RST    = 8'h00;
  localparam logic [7:0] ANODE_RST = 8'h7F;
  localparam logic [7:0] ZS_RST    = 8'hFF;
  localparam logic [7:0] ZS_LO_RST = 8'h00;
  localparam logic [7:0] BOOST_RST = 8'h08;

  localparam logic [7:0] REG_ADDR [NREG] = '{
    ADDR_OUT1, ADDR_OUT2, ADDR_AB, 8'h1B, 8'h1C, 8'h1D, 8'h1E,
    ADDR_FS_A, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, ADDR_ANODE, ADDR_PUMP,
    ADDR_EN, ADDR_PAT, ADDR_ZS_HI, ADDR_ZS_MID, ADDR_ZS_LO, ADDR_BOOST,
    ADDR_ALS};
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'hFF, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0F,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h07,
    8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h7F};
  localparam logic [7:0] REG_RST [NREG] = '{
    OUT1_RST, OUT2_RST, CFG_RST, CFG_RST, CFG_RST, CFG_RST, CFG_RST,
    FS_RST, FS_RST, FS_RST, FS_RST, FS_RST, FS_RST, ANODE_RST, CFG_RST,
    CFG_RST, CFG_RST, ZS_RST, ZS_RST, ZS_LO_RST, BOOST_RST, CFG_RST};

  // field positions
  localparam int AB_A_SRC    = 0;
  localparam int AB_A_LIN    = 1;
  localparam int AB_B_SRC    = 2;
  localparam int AB_B_LIN    = 3;
  localparam int LV_CTL_LO   = 0;
  localparam int LV_CTL_HI   = 1;
  localparam int LV_LIN      = 2;
  localparam int LV_PAT      = 3;
  localparam int OUT1_HV1    = 0;
  localparam int OUT1_HV2    = 1;
  localparam int OUT1_LV1    = 2;
  localparam int OUT1_LV2    = 4;
  localparam int OUT1_LV3    = 6;
  localparam int OUT2_LV4    = 0;
  localparam int OUT2_LV5    = 2;
  localparam int PUMP_OFF    = 0;
  localparam int PUMP_GAIN   = 1;
  localparam int BST_FREQ    = 0;
  localparam int BST_OVP     = 1;
  localparam int BST_PWM_POL = 3;

  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  localparam logic [2:0] BANK_IDX_C    = 3'h2;

  typedef logic [2:0] lbc_bank_t;
  typedef enum logic [2:0] {
    SRC_LEVEL, SRC_SET1, SRC_SET2, SRC_SET3, SRC_PATTERN
  } lbc_src_e;
  typedef enum logic [1:0] {GAIN_AUTO, GAIN_1X, GAIN_2X} lbc_gain_e;
  typedef enum logic [1:0] {OVP_16V, OVP_24V, OVP_32V, OVP_40V} lbc_ovp_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
  } lbc_i2c_e;

  typedef struct packed {
    logic       enable;
    logic       linear_map;
    logic       pattern_en;
    logic [7:0] full_scale;
    lbc_src_e   source;
  } lbc_bank_s;

  typedef struct packed {
    logic      disable_pump;
    lbc_gain_e gain;
  } lbc_pump_s;

  typedef struct packed {
    logic     pwm_active_high;
    lbc_ovp_e overvoltage_trip;
    logic     freq_1mhz;
  } lbc_boost_s;

endpackage

// >>> rtl/lbc_top.sv
/*
 * lbc_top: LED bank configuration registers behind a two-wire serial
 * slave port, with decoded controls for banks, sinks, pump and boost.
 * Assumes: SCL_I and SDA_I are already synchronous to CORE_CLK_I; the
 * pad combines SDA_O and SDA_OE_N_O into an open-drain line.
 */
`timescale 1ns/100ps
module lbc_top
  import lbc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary value
) (
  // clock and reset
  input  wire logic                       CORE_CLK_I,
  input  wire logic                       RST_N_I,
  // serial port
  input  wire logic                       SCL_I,
  input  wire logic                       SDA_I,
  output logic                            SDA_O,
  output logic                            SDA_OE_N_O,
  // bank and sink controls
  output lbc_bank_s [NBANK-1:0]           BANK_O,
  output lbc_bank_t [NSINK-1:0]           SINK_BANK_O,
  output logic      [NSINK-1:0]           ANODE_O,
  // supplies
  output lbc_pump_s                       PUMP_O,
  output lbc_boost_s                      BOOST_O,
  // pattern and light sensor
  output logic      [NPAT-1:0]            PATTERN_EN_O,
  output logic      [NPAT-1:0]            PATTERN_SCALE_O,
  output logic      [NZONE-1:0][3:0]      ZONE_SCALE_O,
  output logic      [6:0]                 ALS_GAIN_O,
  output logic                            ALS_HIZ_O
);

  logic [1:0]  rst_pipe;
  logic        rst_n;
  logic        scl_q;
  logic        sda_q;
  logic        start_c;
  logic        stop_c;
  logic        scl_rise;
  logic        scl_fall;
  lbc_i2c_e    state;
  lbc_i2c_e    after_ack;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  txreg;
  logic [7:0]  ptr;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic [7:0]  regs_q [NREG];

  // reset release through two flops
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // line edge detection
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= SCL_I;
      sda_q <= SDA_I;
    end
  end
  assign start_c  = scl_q & SCL_I & sda_q & ~SDA_I;
  assign stop_c   = scl_q & SCL_I & ~sda_q & SDA_I;
  assign scl_rise = ~scl_q & SCL_I;
  assign scl_fall = scl_q & ~SCL_I;

  // serial slave: address, pointer, data with auto increment
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      after_ack  <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      txreg      <= 8'h00;
      ptr        <= 8'h00;
      wr_en      <= 1'b0;
      wr_addr    <= 8'h00;
      wr_data    <= 8'h00;
      SDA_OE_N_O <= 1'b1;
      SDA_O      <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      SDA_O <= 1'b0;
      if (start_c) begin
        state      <= ST_ADDR;
        bit_cnt    <= 4'h0;
        SDA_OE_N_O <= 1'b1;
      end else if (stop_c) begin
        state      <= ST_IDLE;
        SDA_OE_N_O <= 1'b1;
      end else begin
        case (state)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], SDA_I};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == I2C_BYTE_BITS) begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shreg[7:1] == DEV_ADDR) begin
                  SDA_OE_N_O <= 1'b0;
                  state      <= ST_ACK;
                  after_ack  <= shreg[0] ? ST_RDATA : ST_PTR;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (state == ST_PTR) begin
                ptr        <= shreg;
                SDA_OE_N_O <= 1'b0;
                state      <= ST_ACK;
                after_ack  <= ST_WDATA;
              end else begin
                wr_en      <= 1'b1;
                wr_addr    <= ptr;
                wr_data    <= shreg;
                ptr        <= ptr + 8'h01;
                SDA_OE_N_O <= 1'b0;
                state      <= ST_ACK;
                after_ack  <= ST_WDATA;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              state   <= after_ack;
              bit_cnt <= 4'h0;
              if (after_ack == ST_RDATA) begin
                txreg      <= rd_data;
                SDA_OE_N_O <= rd_data[7];
                ptr        <= ptr + 8'h01;
              end else begin
                SDA_OE_N_O <= 1'b1;
              end
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == I2C_BYTE_BITS) begin
                SDA_OE_N_O <= 1'b1;
                state      <= ST_RACK;
                bit_cnt    <= 4'h0;
              end else begin
                txreg      <= {txreg[6:0], 1'b0};
                SDA_OE_N_O <= txreg[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              // master nack ends the read
              state     <= SDA_I ? ST_IDLE : ST_ACK;
              after_ack <= ST_RDATA;
            end
          end
          default: begin
            SDA_OE_N_O <= 1'b1;
          end
        endcase
      end
    end
  end

  // register storage, reserved bits held at zero
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
        regs_q[i] <= REG_RST[i];
      end else if (wr_en && wr_addr == REG_ADDR[i]) begin
        regs_q[i] <= wr_data & REG_MASK[i];
      end
    end

    AST_UNUSED_ZERO: assert property (
      @(posedge CORE_CLK_I) disable iff (!rst_n)
      (regs_q[i] & ~REG_MASK[i]) == 8'h00)
      else $error("reserved bits not zero");
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_data = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (ptr == REG_ADDR[i]) begin
        rd_data = regs_q[i];
      end
    end
  end

  function automatic lbc_src_e lv_source(input logic [7:0] cfg);
    if (!cfg[LV_CTL_HI]) begin
      return SRC_LEVEL;
    end else if (cfg[LV_PAT]) begin
      return SRC_PATTERN;
    end else if (cfg[LV_CTL_LO]) begin
      return SRC_SET3;
    end else begin
      return SRC_SET2;
    end
  endfunction

  // bank controls
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      BANK_O <= '0;
    end else begin
      for (int b = 0; b < NBANK; b++) begin
        BANK_O[b].enable     <= regs_q[IDX_EN][b];
        BANK_O[b].full_scale <= regs_q[IDX_FS_A + b];
      end
      BANK_O[0].linear_map <= regs_q[IDX_AB][AB_A_LIN];
      BANK_O[1].linear_map <= regs_q[IDX_AB][AB_B_LIN];
      BANK_O[0].pattern_en <= 1'b0;
      BANK_O[1].pattern_en <= 1'b0;
      BANK_O[0].source <= regs_q[IDX_AB][AB_A_SRC] ? SRC_SET1 : SRC_LEVEL;
      BANK_O[1].source <= regs_q[IDX_AB][AB_B_SRC] ? SRC_SET2 : SRC_LEVEL;
      for (int b = 2; b < NBANK; b++) begin
        BANK_O[b].linear_map <= regs_q[IDX_LV_C + b - 2][LV_LIN];
        BANK_O[b].pattern_en <= regs_q[IDX_LV_C + b - 2][LV_PAT];
        BANK_O[b].source     <= lv_source(regs_q[IDX_LV_C + b - 2]);
      end
    end
  end

  // sink routing and anode connects
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      SINK_BANK_O <= '0;
      ANODE_O     <= '0;
    end else begin
      SINK_BANK_O[0] <= {2'h0, regs_q[IDX_OUT1][OUT1_HV1]};
      SINK_BANK_O[1] <= {2'h0, regs_q[IDX_OUT1][OUT1_HV2]};
      SINK_BANK_O[2] <= BANK_IDX_C + {1'b0, regs_q[IDX_OUT1][OUT1_LV1 +: 2]};
      SINK_BANK_O[3] <= BANK_IDX_C + {1'b0, regs_q[IDX_OUT1][OUT1_LV2 +: 2]};
      SINK_BANK_O[4] <= BANK_IDX_C + {1'b0, regs_q[IDX_OUT1][OUT1_LV3 +: 2]};
      SINK_BANK_O[5] <= BANK_IDX_C + {1'b0, regs_q[IDX_OUT2][OUT2_LV4 +: 2]};
      SINK_BANK_O[6] <= BANK_IDX_C + {1'b0, regs_q[IDX_OUT2][OUT2_LV5 +: 2]};
      ANODE_O <= regs_q[IDX_ANODE][NSINK-1:0];
    end
  end

  // pump, boost and light sensor controls
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PUMP_O     <= '0;
      BOOST_O    <= '0;
      ALS_GAIN_O <= 7'h00;
      ALS_HIZ_O  <= 1'b1;
    end else begin
      PUMP_O.disable_pump <= regs_q[IDX_PUMP][PUMP_OFF];
      if (!regs_q[IDX_PUMP][PUMP_GAIN + 1]) begin
        PUMP_O.gain <= GAIN_AUTO;
      end else if (regs_q[IDX_PUMP][PUMP_GAIN]) begin
        PUMP_O.gain <= GAIN_2X;
      end else begin
        PUMP_O.gain <= GAIN_1X;
      end
      BOOST_O.pwm_active_high <= regs_q[IDX_BOOST][BST_PWM_POL];
      BOOST_O.overvoltage_trip <=
        lbc_ovp_e'(regs_q[IDX_BOOST][BST_OVP +: 2]);
      BOOST_O.freq_1mhz <= regs_q[IDX_BOOST][BST_FREQ];
      ALS_GAIN_O <= regs_q[IDX_ALS][6:0];
      ALS_HIZ_O  <= regs_q[IDX_ALS][6:0] == 7'h00;
    end
  end

  // pattern enables and zone scalers
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PATTERN_EN_O    <= '0;
      PATTERN_SCALE_O <= '0;
      ZONE_SCALE_O    <= '0;
    end else begin
      for (int p = 0; p < NPAT; p++) begin
        PATTERN_EN_O[p]    <= regs_q[IDX_PAT][2*p];
        PATTERN_SCALE_O[p] <= regs_q[IDX_PAT][2*p+1];
      end
      ZONE_SCALE_O[4] <= regs_q[IDX_ZS_HI][7:4];
      ZONE_SCALE_O[3] <= regs_q[IDX_ZS_HI][3:0];
      ZONE_SCALE_O[2] <= regs_q[IDX_ZS_MID][7:4];
      ZONE_SCALE_O[1] <= regs_q[IDX_ZS_MID][3:0];
      ZONE_SCALE_O[0] <= regs_q[IDX_ZS_LO][3:0];
    end
  end

  AST_BANK_A_SOURCE: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    $past(rst_n) |-> BANK_O[0].source ==
      ($past(regs_q[IDX_AB][AB_A_SRC]) ? SRC_SET1 : SRC_LEVEL))
    else $error("bank A source wrong");

  AST_BANK_B_SOURCE: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    $past(rst_n) |-> BANK_O[1].source ==
      ($past(regs_q[IDX_AB][AB_B_SRC]) ? SRC_SET2 : SRC_LEVEL))
    else $error("bank B source wrong");

  AST_MAP_MODE: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    $past(rst_n) |-> BANK_O[0].linear_map == $past(regs_q[IDX_AB][1]) &&
      BANK_O[1].linear_map == $past(regs_q[IDX_AB][3]) &&
      BANK_O[2].linear_map == $past(regs_q[IDX_LV_C][2]))
    else $error("mapping mode wrong");

  AST_PATTERN_OVERRIDE: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    (regs_q[IDX_LV_C + 1][3:1] == 3'h7) |=> BANK_O[3].source == SRC_PATTERN)
    else $error("pattern did not override zone targets");

  AST_LV_SET3: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    (regs_q[IDX_LV_C + 2][3:0] == 4'h3) |=> BANK_O[4].source == SRC_SET3)
    else $error("low bank set3 decode wrong");

  AST_CFG_C_WRITE: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    (wr_en && wr_addr == ADDR_LV_C) |=> ##1
      BANK_O[2].pattern_en == $past(wr_data[3], 2))
    else $error("write to bank C config lost");

  AST_ENABLE: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    $past(rst_n) |-> BANK_O[5].enable == $past(regs_q[IDX_EN][5]))
    else $error("bank F enable wrong");

  AST_ANODE: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    $past(rst_n) |-> ANODE_O == $past(regs_q[IDX_ANODE][6:0]))
    else $error("anode connect wrong");

  AST_PUMP_GAIN: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    (regs_q[IDX_PUMP][2:1] == 2'h2) |=> PUMP_O.gain == GAIN_1X)
    else $error("pump gain 1x decode wrong");

  AST_PUMP_OFF: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    regs_q[IDX_PUMP][0] [*2] |-> PUMP_O.disable_pump)
    else $error("pump disable lost");

  AST_BOOST: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    $past(rst_n) |-> BOOST_O.pwm_active_high == $past(regs_q[IDX_BOOST][3]) &&
      BOOST_O.freq_1mhz == $past(regs_q[IDX_BOOST][0]))
    else $error("polarity or frequency wrong");

  AST_OVP: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    (regs_q[IDX_BOOST][2:1] == 2'h3) |=> BOOST_O.overvoltage_trip == OVP_40V)
    else $error("overvoltage field wrong");

  AST_ALS_HIZ: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    $past(rst_n) |-> ALS_HIZ_O == ($past(regs_q[IDX_ALS]) == 8'h00))
    else $error("light input impedance wrong");

  AST_PATTERN_BITS: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    $past(rst_n) |-> PATTERN_SCALE_O[3] == $past(regs_q[IDX_PAT][7]) &&
      PATTERN_EN_O[3] == $past(regs_q[IDX_PAT][6]))
    else $error("pattern enable bits wrong");

  AST_ZONE_SCALE: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    $past(rst_n) |-> ZONE_SCALE_O[4] == $past(regs_q[IDX_ZS_HI][7:4]) &&
      ZONE_SCALE_O[0] == $past(regs_q[IDX_ZS_LO][3:0]))
    else $error("zone scaler wrong");

  AST_ROUTE: assert property (
    @(posedge CORE_CLK_I) disable iff (!rst_n)
    $past(rst_n) |-> SINK_BANK_O[2] ==
      3'(2 + $past(regs_q[IDX_OUT1][3:2])))
    else $error("sink routing wrong");

endmodule // lbc_top

// >>> tb/lbc_host.sv
/*
 * lbc_host: two-wire serial master model that drives the register port.
 * Assumes: the bench combines sda_o with the slave's open-drain output and
 * feeds the wire level back on sda_i; scl stays high for 4 core clocks and low for 5.
 */
`timescale 1ns/100ps
module lbc_host #(
  parameter logic [6:0] DEV = 7'h2A  // arbitrary value
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic [6:0] dev;
  int         nacks;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    dev = DEV;
    nacks = 0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // data moves one clock after scl falls, sampled at end of high phase
  task automatic bitx(input logic b, output logic r);
    w(1);
    sda_o = b;
    w(4);
    scl_o = 1'b1;
    w(4);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic start();
    sda_o = 1'b1;
    w(2);
    scl_o = 1'b1;
    w(4);
    sda_o = 1'b0;
    w(4);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    w(1);
    sda_o = 1'b0;
    w(4);
    scl_o = 1'b1;
    w(4);
    sda_o = 1'b1;
    w(4);
  endtask
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    if (r !== 1'b0) nacks++;
  endtask
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] b[$]);
    start();
    tx({dev, 1'b0});
    tx(p);
    foreach (b[i]) tx(b[i]);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, input int n,
                    output logic [7:0] o[$]);
    logic [7:0] d;
    o = {};
    start();
    tx({dev, 1'b0});
    tx(p);
    start();
    tx({dev, 1'b1});
    for (int i = 0; i < n; i++) begin
      rx(i == n - 1, d);
      o.push_back(d);
    end
    stop();
  endtask
endmodule // lbc_host

// >>> tb/lbc_top_tb.sv
/*
 * lbc_top_tb: self-checking bench for the LED bank configuration block.
 * Assumes: lbc_host drives the serial port; sda has a pull-up.
 */
`timescale 1ns/100ps
module lbc_top_tb;
  import lbc_pkg::*;
  localparam logic [6:0] DEV = 7'h2A;  // arbitrary value
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  scl;
  logic                  sda_h;
  logic                  sda_o;
  logic                  sda_oe_n;
  wire                   sda_w = sda_h & (sda_oe_n | sda_o);
  lbc_bank_s [NBANK-1:0] bank;
  lbc_bank_t [NSINK-1:0] sink;
  logic [NSINK-1:0]      anode;
  lbc_pump_s             pump;
  lbc_boost_s            boost;
  logic [NPAT-1:0]       pen;
  logic [NPAT-1:0]       psc;
  logic [NZONE-1:0][3:0] zs;
  logic [6:0]            als_g;
  logic                  als_hiz;
  logic [7:0]            q[$];
  int                    fail_count = 0;
  int                    n_checks = 0;
  int                    cyc = 0;
  always #12.5 clk = ~clk;
  lbc_host #(.DEV(DEV)) host_u (.clk_i(clk), .sda_i(sda_w), .scl_o(scl),
    .sda_o(sda_h));
  lbc_top #(.DEV_ADDR(DEV)) dut_u (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n),
    .BANK_O(bank), .SINK_BANK_O(sink), .ANODE_O(anode), .PUMP_O(pump),
    .BOOST_O(boost), .PATTERN_EN_O(pen), .PATTERN_SCALE_O(psc),
    .ZONE_SCALE_O(zs), .ALS_GAIN_O(als_g), .ALS_HIZ_O(als_hiz));
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s exp %0h got %0h", n, e, s);
    end
  endtask
  function automatic lbc_src_e lvsrc(logic [7:0] d);
    if (d[3] && d[1]) return SRC_PATTERN;
    if (d[1]) return d[0] ? SRC_SET3 : SRC_SET2;
    return SRC_LEVEL;
  endfunction
  task automatic route(logic [7:0] a, logic [7:0] b);
    logic [9:0] f;
    f = {b[3:0], a[7:2]};
    chk("hv1", {7'h0, a[0]}, {5'h0, sink[0]});
    chk("hv2", {7'h0, a[1]}, {5'h0, sink[1]});
    for (int i = 0; i < 5; i++)
      chk("lv", 8'h2 + f[2*i +: 2], {5'h0, sink[i+2]});
  endtask
  task automatic t_reset();
    logic [7:0] rb [8] = '{8'h7F, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
                           8'h00, 8'h08};
    chk("anode", 8'h7F, {1'b0, anode});
    chk("pump", 8'h00, {5'h0, pump});
    chk("boost", 8'h08, {4'h0, boost});
    chk("zs43", 8'hFF, {zs[4], zs[3]});
    chk("zs21", 8'hFF, {zs[2], zs[1]});
    chk("zs0", 8'h00, {4'h0, zs[0]});
    chk("pat", 8'h00, {pen, psc});
    chk("als", 8'h80, {als_hiz, als_g});
    for (int i = 0; i < NBANK; i++)
      chk("bank", 8'h00, {bank[i].enable, bank[i].linear_map,
        bank[i].pattern_en, 2'b0, bank[i].source});
    route(8'h92, 8'h0F);
    host_u.rd(ADDR_ANODE, 8, q);
    foreach (rb[i]) chk("rb", rb[i], q[i]);
    host_u.wr(ADDR_OUT1, '{8'h6D, 8'hF4});
    route(8'h6D, 8'h04);
    $display("t_reset done");
  endtask
  task automatic t_ab();
    logic [3:0] d;
    for (int k = 0; k < 16; k++) begin
      d = k[3:0];
      host_u.wr(ADDR_AB, '{{4'hF, d}});
      chk("a_src", {5'h0, d[0] ? SRC_SET1 : SRC_LEVEL},
        {5'h0, bank[0].source});
      chk("b_src", {5'h0, d[2] ? SRC_SET2 : SRC_LEVEL},
        {5'h0, bank[1].source});
      chk("ab_lin", {6'h0, d[3], d[1]},
        {6'h0, bank[1].linear_map, bank[0].linear_map});
      host_u.rd(ADDR_AB, 1, q);
      chk("ab_rb", {4'h0, d}, q[0]);
    end
    $display("t_ab done");
  endtask
  task automatic t_lv();
    logic [7:0] p [8] = '{8'h04, 8'h0E, 8'h03, 8'h0B, 8'h0A, 8'h09,
                          8'h06, 8'hF2};
    for (int k = 0; k < 2; k++) begin
      host_u.wr(ADDR_LV_C, '{p[4*k], p[4*k+1], p[4*k+2], p[4*k+3]});
      for (int i = 0; i < 4; i++) begin
        chk("lv_src", {5'h0, lvsrc(p[4*k+i])},
          {5'h0, bank[i+2].source});
        chk("lv_cfg", {6'h0, p[4*k+i][3:2]},
          {6'h0, bank[i+2].pattern_en, bank[i+2].linear_map});
      end
    end
    host_u.rd(8'h1E, 1, q);
    chk("lv_rb", 8'h02, q[0]);
    // full-scale codes keep all eight bits
    host_u.wr(ADDR_FS_A, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
    for (int i = 0; i < NBANK; i++)
      chk("fs", 8'(8'h11 * (i + 1)), bank[i].full_scale);
    $display("t_lv done");
  endtask
  task automatic t_misc();
    logic [7:0] v [8] = '{8'h2A, 8'h05, 8'h3F, 8'hA5, 8'h12, 8'h34,
                          8'hF6, 8'hFF};
    logic [7:0] a [3] = '{8'h00, 8'h01, 8'hFF};
    host_u.wr(ADDR_ANODE, '{v[0], v[1], v[2], v[3], v[4], v[5], v[6],
      v[7]});
    chk("anode", 8'h2A, {1'b0, anode});
    chk("pump", {5'h0, 1'b1, GAIN_1X}, {5'h0, pump});
    for (int i = 0; i < NBANK; i++)
      chk("en", 8'h01, {7'h0, bank[i].enable});
    chk("pat", {4'b0011, 4'b1100}, {pen, psc});
    chk("zs43", 8'h12, {zs[4], zs[3]});
    chk("zs21", 8'h34, {zs[2], zs[1]});
    chk("zs0", 8'h06, {4'h0, zs[0]});
    host_u.rd(ADDR_ZS_LO, 2, q);
    chk("rb", 8'h06, q[0]);
    chk("rb", 8'h0F, q[1]);
    for (int g = 0; g < 4; g++) begin
      host_u.wr(ADDR_PUMP, '{8'(g << 1)});
      chk("gain", {6'h0, g < 2 ? GAIN_AUTO : g == 2 ? GAIN_1X : GAIN_2X},
        {6'h0, pump.gain});
    end
    for (int d = 0; d < 16; d++) begin
      host_u.wr(ADDR_BOOST, '{8'(d)});
      chk("boost", {4'h0, d[3], d[2:1], d[0]}, {4'h0, boost});
    end
    foreach (a[i]) begin
      host_u.wr(ADDR_ALS, '{a[i]});
      chk("als", {a[i][6:0] == 7'h0, a[i][6:0]}, {als_hiz, als_g});
    end
    $display("t_misc done");
  endtask
  task automatic t_ref();
    int n;
    host_u.wr(8'h2D, '{8'h5A});
    host_u.rd(8'h2D, 1, q);
    chk("unmapped", 8'h00, q[0]);
    n = host_u.nacks;
    host_u.dev = 7'h15;
    host_u.wr(ADDR_EN, '{8'h00});
    host_u.dev = DEV;
    chk("nack", 8'h03, 8'(host_u.nacks - n));
    chk("en_kept", 8'h01, {7'h0, bank[0].enable});
    $display("t_ref done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_ab();
    t_lv();
    t_misc();
    t_ref();
    summarize();
  end
endmodule // lbc_top_tb
